// ==== rtl/aqs_map.svh ====
// Register offsets, field positions, reset values and sizes of the acquisition sequencer.
`ifndef AQS_MAP_SVH
`define AQS_MAP_SVH
`define AQS_ADR_CTRL 8'h00
`define AQS_ADR_RECLEN 8'h04
`define AQS_ADR_DECIM 8'h08
`define AQS_ADR_TMO 8'h0C
`define AQS_ADR_TRIGLVL 8'h10
`define AQS_ADR_STATUS 8'h14
`define AQS_ADR_ELAPSED 8'h18
`define AQS_ADR_NEWEST 8'h1C
`define AQS_CTRL_RUN 0
`define AQS_CTRL_STOP 1
`define AQS_CTRL_AUTO 2
`define AQS_ST_RUN 0
`define AQS_ST_ARMED 1
`define AQS_ST_STATE_LO 2
`define AQS_ST_STATE_HI 4
`define AQS_ST_VIOL 5
`define AQS_ST_CNT_LO 16
`define AQS_RECLEN_RST 32'h00000400
`define AQS_DECIM_RST 32'h00000001
`define AQS_TMO_RST 32'h00989680
`define AQS_TRIGLVL_RST 32'h00000000
`define AQS_MEM_DEPTH 20000000
`define AQS_CNT_MAX 16'hFFFF
`endif

// ==== rtl/aqs_pkg.sv ====
// Types shared by the acquisition sequencer and its users.
package aqs_pkg;
    localparam int AQS_NCH = 4;
    localparam int AQS_SW = 16;
    typedef logic signed [AQS_SW-1:0] aqs_sample_t;
    // One converter beat for all channels in parallel.
    typedef struct packed {
        logic valid;
        aqs_sample_t [AQS_NCH-1:0] data;
    } aqs_adc_t;
    // One read-out beat towards post-processing.
    typedef struct packed {
        logic valid;
        logic last;
        aqs_sample_t [AQS_NCH-1:0] data;
    } aqs_pp_t;
    typedef enum logic [2:0] {
        AQS_IDLE = 3'b000,
        AQS_ARM = 3'b001,
        AQS_WAIT = 3'b011,
        AQS_REC = 3'b010,
        AQS_READ = 3'b110,
        AQS_PPW = 3'b111
    } aqs_state_t;
endpackage

// ==== rtl/aqs_sequencer.sv ====
// Acquisition phase sequencer: filter, decimate, trigger, record and read out.
// How it works
// - Acquisition and post-processing phases never overlap; memory has one owner.
// - Continuous capture alternates one acquisition with one post-processing phase.
// - Every acquisition phase arms the trigger first; nothing stored before arming.
// - Only a trigger event after arming starts writing a record.
// - Trigger derives events from digitized samples, in parallel with processing.
// - Acquisition ends when stored samples equal the configured record length.
// - Record length and sample rate (decimation) are software settings.
// - After acquisition the new record is read out to post-processing.
// - Next acquisition waits for post-processing to report completion.
// - All channels are filtered and decimated in parallel before storing.
// - A filter and decimation stage sits between converter and memory.
// - Records are indexed from one minus record count up to zero.
// - Top rate equals converter rate; lower rates come from decimation.
// - Memory holds 20 M samples per channel; depth is a parameter.
// - Auto mode forces an internal trigger after the timeout.
// - Normal mode uses real triggers only and tracks time since last.
// - An analysis violation stops continuous capture, keeping the data.
// - Newest record is index zero, older ones count backwards.
// - Records form a ring over linear memory; newest overwrites oldest.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "aqs_map.svh"
module aqs_sequencer #(
    parameter int MEM_DEPTH = `AQS_MEM_DEPTH
) (
    input logic clk_sys,
    input logic srst,
    input logic wbCyc,
    input logic wbStb,
    input logic wbWe,
    input logic [7:0] wbAdr,
    input logic [3:0] wbSel,
    input logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    input aqs_pkg::aqs_adc_t adcIn,
    input logic violation,
    input logic ppReady,
    input logic ppDone,
    output aqs_pkg::aqs_pp_t ppOut,
    output logic armed,
    output logic running
);
    localparam int NCH = aqs_pkg::AQS_NCH;
    localparam int SW = aqs_pkg::AQS_SW;
    localparam int AW = $clog2(MEM_DEPTH);
    localparam logic [AW-1:0] LAST_ADR = AW'(MEM_DEPTH - 1);

    // Applies Wishbone byte selects to a stored word.
    function automatic logic [31:0] byteWrite(input logic [31:0] old,
            input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Rising crossing of a level between two consecutive samples.
    function automatic logic crossUp(input aqs_pkg::aqs_sample_t prev,
            input aqs_pkg::aqs_sample_t cur, input aqs_pkg::aqs_sample_t lvl);
        return (prev < lvl) && (cur >= lvl);
    endfunction

    aqs_pkg::aqs_state_t state;
    aqs_pkg::aqs_state_t next_state;
    logic [31:0] recLen;
    logic [31:0] decim;
    logic [31:0] tmo;
    logic [31:0] trigLvl;
    logic autoMode;
    logic violSeen;
    logic [31:0] elapsed;
    logic [31:0] tmoCnt;
    logic [31:0] decCnt;
    logic [31:0] stored;
    logic [31:0] rdLeft;
    logic [15:0] recCount;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] recBase;
    logic [AW-1:0] newest;
    logic filtValid;
    logic ppV;
    logic ppL;
    aqs_pkg::aqs_sample_t prevS [NCH];
    aqs_pkg::aqs_sample_t filtS [NCH];
    aqs_pkg::aqs_sample_t rdWord [NCH];

    // Bus decode; an access is answered once, in the cycle after it is seen.
    wire wbReq = wbCyc && wbStb && !wbAck;
    wire wbWr = wbReq && wbWe;
    wire wrCtrl = wbWr && (wbAdr == `AQS_ADR_CTRL);
    wire runCmd = wrCtrl && wbSel[0] && wbDatW[`AQS_CTRL_RUN];
    wire stopCmd = wrCtrl && wbSel[0] && wbDatW[`AQS_CTRL_STOP];
    wire [31:0] ctrlWord = byteWrite({29'h0, autoMode, 2'h0}, wbDatW, wbSel);

    // Trigger watches raw converter samples, not the filtered stream.
    wire realTrig = adcIn.valid && crossUp(prevS[0], adcIn.data[0], trigLvl[SW-1:0]);
    wire autoTrig = autoMode && (tmoCnt >= tmo);
    wire startRec = realTrig || autoTrig;
    wire [31:0] lenEff = (recLen == 32'h0) ? 32'h1 : recLen;
    wire [31:0] decEff = (decim == 32'h0) ? 32'h1 : decim;
    wire decValid = filtValid && (decCnt == 32'h0);
    wire recWrite = (state == aqs_pkg::AQS_REC) && decValid;
    wire recDone = recWrite && (stored + 32'h1 == lenEff);
    wire readStep = (state == aqs_pkg::AQS_READ) && (rdLeft != 32'h0) && (!ppV || ppReady);
    wire readEnd = (state == aqs_pkg::AQS_READ) && ppV && ppL && ppReady;
    wire [AW-1:0] wrPtrInc = (wrPtr == LAST_ADR) ? '0 : wrPtr + AW'(1);
    wire [AW-1:0] rdPtrInc = (rdPtr == LAST_ADR) ? '0 : rdPtr + AW'(1);
    // Low half of the status word: run, armed, state code and the violation flag.
    wire [15:0] stCode = {10'h0, violSeen, state, armed, running};

    // Register read multiplexer; unmapped offsets read as zero.
    wire [31:0] rdMux =
        (wbAdr == `AQS_ADR_CTRL) ? {29'h0, autoMode, 2'h0} :
        (wbAdr == `AQS_ADR_RECLEN) ? recLen :
        (wbAdr == `AQS_ADR_DECIM) ? decim :
        (wbAdr == `AQS_ADR_TMO) ? tmo :
        (wbAdr == `AQS_ADR_TRIGLVL) ? trigLvl :
        (wbAdr == `AQS_ADR_STATUS) ? {recCount, stCode} :
        (wbAdr == `AQS_ADR_ELAPSED) ? elapsed :
        (wbAdr == `AQS_ADR_NEWEST) ? 32'(newest) : 32'h0;

    // Phase sequencing; post-processing only starts once recording is done.
    always_comb begin
        next_state = state;
        unique case (state)
            aqs_pkg::AQS_IDLE: begin
                if (running) begin
                    next_state = aqs_pkg::AQS_ARM;
                end
            end
            aqs_pkg::AQS_ARM: begin
                next_state = running ? aqs_pkg::AQS_WAIT : aqs_pkg::AQS_IDLE;
            end
            aqs_pkg::AQS_WAIT: begin
                if (!running) begin
                    next_state = aqs_pkg::AQS_IDLE;
                end else if (startRec) begin
                    next_state = aqs_pkg::AQS_REC;
                end
            end
            aqs_pkg::AQS_REC: begin
                if (recDone) begin
                    next_state = aqs_pkg::AQS_READ;
                end
            end
            aqs_pkg::AQS_READ: begin
                if (readEnd) begin
                    next_state = aqs_pkg::AQS_PPW;
                end
            end
            aqs_pkg::AQS_PPW: begin
                if (ppDone) begin
                    next_state = running ? aqs_pkg::AQS_ARM : aqs_pkg::AQS_IDLE;
                end
            end
            default: next_state = aqs_pkg::AQS_IDLE;
        endcase
    end

    // Wishbone slave: registered answer, one cycle after the request.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0;
        end else begin
            wbAck <= wbReq;
            wbDatR <= wbReq ? rdMux : 32'h0;
        end
    end

    // Software settings for length, rate, timeout and level.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            recLen <= `AQS_RECLEN_RST;
            decim <= `AQS_DECIM_RST;
            tmo <= `AQS_TMO_RST;
            trigLvl <= `AQS_TRIGLVL_RST;
            autoMode <= 1'b0;
        end else if (wbWr) begin
            if (wbAdr == `AQS_ADR_RECLEN) recLen <= byteWrite(recLen, wbDatW, wbSel);
            if (wbAdr == `AQS_ADR_DECIM) decim <= byteWrite(decim, wbDatW, wbSel);
            if (wbAdr == `AQS_ADR_TMO) tmo <= byteWrite(tmo, wbDatW, wbSel);
            if (wbAdr == `AQS_ADR_TRIGLVL) trigLvl <= byteWrite(trigLvl, wbDatW, wbSel);
            if (wrCtrl) autoMode <= ctrlWord[`AQS_CTRL_AUTO];
        end
    end

    // Run state; a violation while running beats a simultaneous run command so data stays put.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            running <= 1'b0;
            violSeen <= 1'b0;
        end else if (violation && running) begin
            running <= 1'b0;
            violSeen <= 1'b1;
        end else if (stopCmd) begin
            running <= 1'b0;
        end else if (runCmd) begin
            running <= 1'b1;
            violSeen <= 1'b0;
        end
    end

    // Trigger arming, timeout and time since the last real trigger.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= aqs_pkg::AQS_IDLE;
            armed <= 1'b0;
            tmoCnt <= 32'h0;
            elapsed <= 32'h0;
        end else begin
            state <= next_state;
            armed <= (next_state == aqs_pkg::AQS_WAIT);
            if (state == aqs_pkg::AQS_ARM || realTrig) begin
                tmoCnt <= 32'h0;
            end else if (state == aqs_pkg::AQS_WAIT && !autoTrig) begin
                tmoCnt <= tmoCnt + 32'h1;
            end
            if (realTrig) begin
                elapsed <= 32'h0;
            end else if (elapsed != 32'hFFFFFFFF) begin
                elapsed <= elapsed + 32'h1;
            end
        end
    end

    // Decimator: one filtered beat in decEff is kept.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            filtValid <= 1'b0;
            decCnt <= 32'h0;
        end else begin
            filtValid <= adcIn.valid;
            if (filtValid) begin
                decCnt <= (decCnt + 32'h1 >= decEff) ? 32'h0 : decCnt + 32'h1;
            end
        end
    end

    // Record bookkeeping in the ring; base of the newest record is index zero.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPtr <= '0;
            recBase <= '0;
            newest <= '0;
            stored <= 32'h0;
            recCount <= 16'h0;
        end else begin
            if (state == aqs_pkg::AQS_WAIT && next_state == aqs_pkg::AQS_REC) begin
                recBase <= wrPtr;
                stored <= 32'h0;
            end else if (recWrite) begin
                wrPtr <= wrPtrInc;
                stored <= stored + 32'h1;
            end
            if (recDone) begin
                newest <= recBase;
                if (recCount != `AQS_CNT_MAX) recCount <= recCount + 16'h1;
            end
        end
    end

    // Read-out of record zero to post-processing with ready back-pressure.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdPtr <= '0;
            rdLeft <= 32'h0;
            ppV <= 1'b0;
            ppL <= 1'b0;
        end else begin
            if (recDone) begin
                rdPtr <= recBase;
                rdLeft <= lenEff;
            end else if (readStep) begin
                rdPtr <= rdPtrInc;
                rdLeft <= rdLeft - 32'h1;
                ppV <= 1'b1;
                ppL <= (rdLeft == 32'h1);
            end else if (ppReady) begin
                ppV <= 1'b0;
                ppL <= 1'b0;
            end
        end
    end

    assign ppOut.valid = ppV;
    assign ppOut.last = ppL;

    // Per-channel filter, memory and read port, all channels in parallel.
    for (genvar c = 0; c < NCH; c++) begin : gChan
        aqs_pkg::aqs_sample_t mem [MEM_DEPTH];
        wire signed [SW:0] sum = {adcIn.data[c][SW-1], adcIn.data[c]} + {prevS[c][SW-1], prevS[c]};
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                prevS[c] <= '0;
                filtS[c] <= '0;
            end else if (adcIn.valid) begin
                prevS[c] <= adcIn.data[c];
                filtS[c] <= sum[SW:1];
            end
        end
        // Memory has no reset; validity is tracked by the record count.
        always_ff @(posedge clk_sys) begin
            if (recWrite) begin
                mem[wrPtr] <= filtS[c];
            end
            if (readStep) begin
                rdWord[c] <= mem[rdPtr];
            end
        end
        assign ppOut.data[c] = rdWord[c];
    end
endmodule

// ==== tb/aqs_sequencer_sva.sv ====
// Port-level assertions for the acquisition sequencer.
`timescale 1ns/1ps
module aqs_sequencer_sva #(
    parameter int MEM_DEPTH = 64
) (
    input logic clk_sys,
    input logic srst,
    input logic wbCyc,
    input logic wbStb,
    input logic wbWe,
    input logic [7:0] wbAdr,
    input logic [31:0] wbDatW,
    input logic wbAck,
    input logic violation,
    input logic ppReady,
    input logic ppDone,
    input aqs_pkg::aqs_pp_t ppOut,
    input logic armed,
    input logic running
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [31:0] recLen;
    logic [31:0] nBeat;
    logic ppWait;
    wire take = ppOut.valid && ppReady;
    // Shadow the record length and count beats, so the final beat can be judged.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            recLen <= 32'h00000400;
            nBeat <= 32'h0;
            ppWait <= 1'b0;
        end else begin
            if (wbCyc && wbStb && wbWe && wbAck && wbAdr == 8'h04) recLen <= wbDatW;
            if (take) nBeat <= ppOut.last ? 32'h0 : nBeat + 32'h1;
            if (take && ppOut.last) ppWait <= 1'b1;
            else if (ppDone) ppWait <= 1'b0;
        end
    end
    AST_ONE_OWNER: assert property (!(armed && ppOut.valid))
        else $error("trigger armed during read-out");
    AST_RESET_IDLE: assert property ($past(srst) |-> !running && !armed && !ppOut.valid)
        else $error("not idle after reset");
    AST_VIOL_STOP: assert property (running && violation |=> !running)
        else $error("violation did not stop capture");
    AST_ARM_RUN: assert property ($rose(armed) |-> $past(running))
        else $error("armed without run");
    AST_HOLD_BEAT: assert property (ppOut.valid && !ppReady |=> ppOut.valid && $stable(ppOut.data))
        else $error("read-out beat not held");
    AST_LAST_LEN: assert property (take && ppOut.last |-> nBeat + 32'h1 == recLen)
        else $error("record length wrong");
    AST_WAIT_DONE: assert property (ppWait |-> !armed)
        else $error("armed before completion");
    AST_ACK_PULSE: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus ack not a one-cycle answer");
    cover property ($fell(armed));
    cover property (take && ppOut.last);
    cover property (running && violation);
endmodule
bind aqs_sequencer aqs_sequencer_sva #(.MEM_DEPTH(MEM_DEPTH)) sva (.*);

// ==== tb/aqs_pp_model.sv ====
// Post-processing side model: takes read-out beats, then reports completion.
`timescale 1ns/1ps
module aqs_pp_model (
    input logic clk_sys,
    input logic srst,
    input aqs_pkg::aqs_pp_t ppOut,
    input logic slow,
    output logic ppReady,
    output logic ppDone,
    output int recs,
    output int beats,
    output aqs_pkg::aqs_pp_t lastBeat
);
    int cur;
    int doneCnt;
    logic tog;
    // Slow mode drops ready every other cycle, as a busy analysis path would.
    assign ppReady = !slow || tog;
    // Completion comes three cycles after the final beat, never before it.
    always_ff @(posedge clk_sys) begin
        tog <= srst ? 1'b0 : !tog;
        ppDone <= !srst && doneCnt == 1;
        if (srst) begin
            cur <= 0;
            recs <= 0;
            beats <= 0;
            doneCnt <= 0;
        end else if (ppOut.valid && ppReady) begin
            cur <= ppOut.last ? 0 : cur + 1;
            if (ppOut.last) begin
                beats <= cur + 1;
                recs <= recs + 1;
                lastBeat <= ppOut;
                doneCnt <= 3;
            end
        end else if (doneCnt > 0) begin
            doneCnt <= doneCnt - 1;
        end
    end
endmodule

// ==== tb/aqs_sequencer_test.sv ====
// Self-checking bench for the acquisition sequencer.
`timescale 1ns/1ps
module aqs_sequencer_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    aqs_pkg::aqs_adc_t adcIn;
    logic violation = 1'b0;
    logic slow = 1'b0;
    logic ppReady;
    logic ppDone;
    aqs_pkg::aqs_pp_t ppOut;
    aqs_pkg::aqs_pp_t lastBeat;
    logic armed;
    logic running;
    int recs;
    int beats;
    int n_fail = 0;
    int total_checks = 0;
    int n;
    logic [31:0] rd;
    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;
    aqs_sequencer #(.MEM_DEPTH(64)) uut (.*);
    aqs_pp_model pp (.*);
    task results();
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    // One classic cycle; the request is held until ack is sampled.
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        chk("bus answer", 1, n < 20);
        if (n >= 20) results();
    endtask
    task waitArm(input logic v);
        n = 0;
        while (armed !== v && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk("armed", v, armed);
        if (armed !== v) results();
    endtask
    task waitRec(input int r, input int len);
        n = 0;
        while (recs != r && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk("records", r, recs);
        chk("beats", len, beats);
        if (recs != r) results();
    endtask
    task tReset();
        chk("running", 0, running);
        bus(0, 8'h04, 0);
        chk("reclen", 32'h00000400, rd);
        bus(0, 8'h08, 0);
        chk("decim", 32'h00000001, rd);
        bus(0, 8'h0C, 0);
        chk("tmo", 32'h00989680, rd);
        bus(0, 8'h14, 0);
        chk("status", 32'h0, rd);
        bus(0, 8'h20, 0);
        chk("unmapped", 32'h0, rd);
    endtask
    // Normal mode waits for a real crossing however long the timeout.
    task tNormal();
        bus(1, 8'h04, 32'h8);
        bus(1, 8'h0C, 32'h14);
        bus(1, 8'h10, 32'h64);
        bus(1, 8'h00, 32'h1);
        waitArm(1);
        repeat (40) @(posedge clk_sys);
        chk("no auto", 1, armed);
        adcIn.data[0] <= 16'sh00C8;
        waitArm(0);
        n = 0;
        while (ppOut.valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        chk("rate 1", 1, n <= 14);
        if (n >= 100) results();
        waitRec(1, 8);
        chk("ch0", 32'h00C8, lastBeat.data[0]);
        chk("ch3", 32'h3, lastBeat.data[3]);
        waitArm(1);
    endtask
    // Auto mode with decimation by four and a stalling reader.
    task tAuto();
        slow <= 1'b1;
        adcIn.data[0] <= 16'sh0000;
        bus(1, 8'h08, 32'h4);
        bus(1, 8'h00, 32'h5);
        waitArm(0);
        n = 0;
        while (ppOut.valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        chk("rate 4", 1, n >= 28 && n <= 40);
        if (n >= 100) results();
        waitRec(2, 8);
        bus(0, 8'h14, 0);
        chk("count", 2, rd[31:16]);
        bus(0, 8'h1C, 0);
        chk("newest", 8, rd);
        // The auto trigger is not a real one, so the elapsed time keeps running.
        bus(0, 8'h18, 0);
        chk("elapsed", 1, rd > 32'h28);
        waitArm(1);
    endtask
    // Longer records run the write pointer off the end of memory and back to zero.
    task tWrap();
        bus(1, 8'h04, 32'h30);
        waitRec(3, 48);
        waitRec(4, 48);
        bus(0, 8'h1C, 0);
        chk("wrapped base", 0, rd);
        bus(0, 8'h14, 0);
        chk("count", 4, rd[31:16]);
        waitArm(1);
    endtask
    // A violation while armed stops capture for good.
    task tViol();
        violation <= 1'b1;
        @(posedge clk_sys);
        violation <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("running", 0, running);
        chk("armed", 0, armed);
        bus(0, 8'h14, 0);
        chk("viol flag", 1, rd[5]);
        repeat (60) @(posedge clk_sys);
        chk("stays", 4, recs);
    endtask
    // A stop command ends capture without raising the violation flag.
    task tStop();
        bus(1, 8'h00, 32'h1);
        waitArm(1);
        bus(1, 8'h00, 32'h2);
        repeat (3) @(posedge clk_sys);
        chk("stopped", 0, running);
        chk("disarmed", 0, armed);
        bus(0, 8'h14, 0);
        chk("stop status", 32'h00040000, rd);
    endtask
    initial begin
        adcIn <= '{valid: 1'b1, data: {16'sh0003, 16'sh0002, 16'sh0001, 16'sh0000}};
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        tReset();
        tNormal();
        tAuto();
        tWrap();
        tViol();
        tStop();
        results();
    end
endmodule
